//--- cstim_consts.vh
/*
 * Register offsets, field positions, reset values and timing counts
 * for the clock select and interval timer block.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef CSTIM_CONSTS_VH
`define CSTIM_CONSTS_VH

////////////////////////////////////////////////////////////////////////////////
// Register offsets (9-bit address, bit 8 is the second bank)
`define CSTIM_ADDR_CPU_USB_CLOCK_CONFIG 9'h030
`define CSTIM_ADDR_TIMER_CLOCK_CONFIG   9'h031
`define CSTIM_ADDR_CLOCK_OUTPUT_CONFIG  9'h032
`define CSTIM_ADDR_USB_LOCK_TRIM_CONFIG 9'h039
`define CSTIM_ADDR_OSC_CONTROL_ZERO     9'h1e0
`define CSTIM_ADDR_RELOAD_LOW           9'h01b
`define CSTIM_ADDR_RELOAD_HIGH          9'h01c

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define CSTIM_RST_CPU_USB_CLOCK_CONFIG  8'h00
`define CSTIM_RST_TIMER_CLOCK_CONFIG    8'h8f
`define CSTIM_RST_CLOCK_OUTPUT_CONFIG   8'h00
`define CSTIM_RST_USB_LOCK_TRIM_CONFIG  8'h00
`define CSTIM_RST_OSC_CONTROL_ZERO      8'h00
`define CSTIM_RST_RELOAD                12'h000

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define CSTIM_CPU_SRC_BIT               0
`define CSTIM_USB_SRC_BIT               5
`define CSTIM_USB_NODIV_BIT             6
`define CSTIM_CAP_DIV_HI                7
`define CSTIM_CAP_DIV_LO                6
`define CSTIM_CAP_SRC_HI                5
`define CSTIM_CAP_SRC_LO                4
`define CSTIM_INT_DIV_HI                3
`define CSTIM_INT_DIV_LO                2
`define CSTIM_INT_SRC_HI                1
`define CSTIM_INT_SRC_LO                0
`define CSTIM_SPEED_HI                  2
`define CSTIM_SPEED_LO                  0
`define CSTIM_SLEEP_TMR_HI              4
`define CSTIM_SLEEP_TMR_LO              3
`define CSTIM_MONITOR_HOLD_BIT          5
`define CSTIM_LOCK_DISABLE_BIT          0
`define CSTIM_FINE_ONLY_BIT             1

////////////////////////////////////////////////////////////////////////////////
// Source codes
`define CSTIM_SRC_OSC24                 2'h0
`define CSTIM_SRC_EXT                   2'h1
`define CSTIM_SRC_OSC32                 2'h2
`define CSTIM_SRC_ALT                   2'h3

////////////////////////////////////////////////////////////////////////////////
// Timing: fixed interval tick
`define CSTIM_FIXED_TICK_US             1024
`define CSTIM_FIXED_TICK_BASE_MHZ       4
`define CSTIM_FIXED_TICK_COUNT          (`CSTIM_FIXED_TICK_US * `CSTIM_FIXED_TICK_BASE_MHZ)
// Last count of the fixed tick, FIXED_TICK_COUNT minus one
`define CSTIM_FIXED_TICK_LAST           13'h0fff

`endif

//--- cstim_div.v
/*
 * Edge-counting clock divider with glitch-free divisor updates.
 * Assumes src_tick marks one rising edge of src_level, both on ref_clk.
 */
`timescale 1ns/10ps

module cstim_div #(
	parameter CNT_W = 8
) (
	input  wire             ref_clk,
	input  wire             rst_n,
	input  wire             src_tick,
	input  wire             src_level,
	input  wire [CNT_W-1:0] divisor,
	input  wire             restart,
	output reg              div_clk,
	output reg              div_tick
);

	reg  [CNT_W-1:0] cnt;
	reg  [CNT_W-1:0] cur_div;
	reg  [CNT_W-1:0] next_cnt;
	reg  [CNT_W-1:0] next_div;
	reg              wrap;
	wire [CNT_W-1:0] half;

	////////////////////////////////////////////////////////////////////////////
	// Divisor changes only at period boundary or on restart
	always @* begin
		wrap     = src_tick && (cnt == cur_div - {{(CNT_W-1){1'b0}}, 1'b1});
		next_cnt = wrap ? {CNT_W{1'b0}} : cnt + {{(CNT_W-1){1'b0}}, 1'b1};
		next_div = wrap ? divisor : cur_div;
	end

	assign half = (next_div + {{(CNT_W-1){1'b0}}, 1'b1}) >> 1;

	always @(posedge ref_clk) begin
		if (!rst_n) begin
			cnt      <= {CNT_W{1'b0}};
			cur_div  <= {{(CNT_W-1){1'b0}}, 1'b1};
			div_clk  <= 1'b0;
			div_tick <= 1'b0;
		end else if (restart || divisor == {CNT_W{1'b0}}) begin
			// Restart holds output low, no runt pulse [R23]
			cnt      <= {CNT_W{1'b0}};
			cur_div  <= (divisor == {CNT_W{1'b0}}) ? {{(CNT_W-1){1'b0}}, 1'b1} : divisor;
			div_clk  <= 1'b0;
			div_tick <= 1'b0;
		end else begin
			div_tick <= wrap;
			if (src_tick) begin
				cnt     <= next_cnt;
				cur_div <= next_div;
			end
			if (next_div == {{(CNT_W-1){1'b0}}, 1'b1})
				div_clk <= src_level;
			else if (src_tick)
				div_clk <= (next_cnt < half); // [R23]
		end
	end

endmodule // cstim_div

//--- cstim_top.v
/*
 * Clock selection, CPU and timer timebase division, USB oscillator
 * lock control, 12-bit interval timer and clock output selection.
 * Assumes all oscillator and pin inputs are sampled levels synchronous
 * to ref_clk, and the CPU register port is synchronous to ref_clk.
 */
`timescale 1ns/10ps
`include "cstim_consts.vh"

// Contract
// R1: CPU speed field resets to zero, 3 MHz
// R2: Speed codes divide by 8,4,2,1,16,32,128
// R3: Monitor bit keeps supply detectors on asleep
// R4: Detector duty independent of sleep interval
// R5: Firmware keeps CPU clock above USB/8
// R6: Firmware sets bank flag before control zero
// R7: Lock runs only with internal USB source
// R8: Lock disable bit stops packet trimming
// R9: Fine-only bit blocks coarse retuning
// R10: Capture divider codes divide 2,4,6,8
// R11: Capture source internal, external, slow, off
// R12: Interval prescaler codes divide 1,2,3,4
// R13: Interval source internal, external, slow, capture
// R14: Timer config resets to capture/six, interval/four
// R15: 12-bit down counter reloads after zero
// R16: Interrupt request on every reload
// R17: Reload never taken from half-written value
// R18: Fixed tick counts capture timebase at 4 MHz
// R19: Clock output select, reset to internal
// R20: CPU source internal or external before divider
// R21: USB clock 12 MHz, optional divide by two
// R22: Sleep forces CPU source to internal, stops oscillator
// R23: Clock switching produces no runt pulses; clock output select changes clock_output_pin source at once, no guard
module cstim_top #(
	parameter TIMER_W = 12
) (
	input  wire       ref_clk,
	input  wire       rst_n,
	input  wire       osc24_in,
	input  wire       osc32_in,
	input  wire       external_clock_pin,
	input  wire [8:0] cpu_addr,
	input  wire [7:0] cpu_wdata,
	input  wire       cpu_wr,
	input  wire       cpu_rd,
	input  wire       extended_io_bank_flag,
	input  wire       sleep_active,
	input  wire       sleep_duty_on,
	input  wire       usb_packet_seen,
	output reg  [7:0] cpu_rdata,
	output wire       processor_clock,
	output wire       usb_engine_clock,
	output wire       capture_timebase,
	output wire       interval_timebase,
	output reg        clock_output_pin,
	output reg        interval_irq,
	output reg        fixed_tick,
	output wire       supply_monitor_enable,
	output wire       osc24_stop,
	output wire [1:0] sleep_interval_sel,
	output wire       osc_lock_enable,
	output wire       osc_coarse_enable,
	output wire       osc_trim_strobe
);

	reg  [7:0]         cpu_usb_clock_config;
	reg  [7:0]         timer_clock_config;
	reg  [7:0]         clock_output_config;
	reg  [7:0]         usb_lock_trim_config;
	reg  [7:0]         oscillator_control_zero;
	reg  [TIMER_W-1:0] interval_reload_value;
	reg  [7:0]         reload_low_stage;
	reg  [TIMER_W-1:0] interval_count;
	reg  [12:0]        fixed_count;
	reg                osc24_q, osc32_q, ext_q;
	reg                osc24_prev, osc32_prev, ext_prev;
	reg                cpu_src_prev;
	reg                usb_src_prev;
	reg  [1:0]         cap_src_prev;
	reg  [1:0]         int_src_prev;
	reg  [7:0]         cpu_divisor;
	reg                cap_src_tick, cap_src_level;
	reg                int_src_tick, int_src_level;
	wire               osc24_tick, osc32_tick, ext_tick;
	wire               bank0_wr;
	wire               cpu_src_ext;
	wire               usb_src_ext;
	wire [1:0]         cap_src, int_src;
	wire [1:0]         cap_div_code;
	wire [1:0]         int_div_code;
	wire [3:0]         cap_divisor;
	wire [2:0]         int_divisor;
	wire [1:0]         usb_divisor;
	wire               cap_tick, int_tick;
	wire               cpu_src_tick, cpu_src_level;

	////////////////////////////////////////////////////////////////////////////
	// Source sampling, edge detect, select history
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			osc24_q    <= 1'b0;
			osc32_q    <= 1'b0;
			ext_q      <= 1'b0;
			osc24_prev <= 1'b0;
			osc32_prev <= 1'b0;
			ext_prev   <= 1'b0;
			cpu_src_prev <= 1'b0;
			usb_src_prev <= 1'b0;
			cap_src_prev <= `CSTIM_SRC_OSC24;
			int_src_prev <= `CSTIM_SRC_ALT;
		end else begin
			osc24_q    <= osc24_in;
			osc32_q    <= osc32_in;
			ext_q      <= external_clock_pin;
			osc24_prev <= osc24_q;
			osc32_prev <= osc32_q;
			ext_prev   <= ext_q;
			cpu_src_prev <= cpu_src_ext;
			usb_src_prev <= usb_src_ext;
			cap_src_prev <= cap_src;
			int_src_prev <= int_src;
		end
	end

	assign osc24_tick = osc24_q & ~osc24_prev;
	assign osc32_tick = osc32_q & ~osc32_prev;
	assign ext_tick   = ext_q & ~ext_prev;

	////////////////////////////////////////////////////////////////////////////
	// Register writes
	assign bank0_wr = cpu_wr & ~extended_io_bank_flag;

	always @(posedge ref_clk) begin
		if (!rst_n) begin
			cpu_usb_clock_config    <= `CSTIM_RST_CPU_USB_CLOCK_CONFIG;
			timer_clock_config      <= `CSTIM_RST_TIMER_CLOCK_CONFIG; // [R14]
			clock_output_config     <= `CSTIM_RST_CLOCK_OUTPUT_CONFIG; // [R19]
			usb_lock_trim_config    <= `CSTIM_RST_USB_LOCK_TRIM_CONFIG;
			oscillator_control_zero <= `CSTIM_RST_OSC_CONTROL_ZERO; // [R1]
			interval_reload_value   <= `CSTIM_RST_RELOAD;
			reload_low_stage        <= 8'h00;
		end else begin
			if (bank0_wr && cpu_addr == `CSTIM_ADDR_CPU_USB_CLOCK_CONFIG)
				cpu_usb_clock_config <= cpu_wdata & 8'h61;
			if (sleep_active)
				cpu_usb_clock_config[`CSTIM_CPU_SRC_BIT] <= 1'b0; // [R22]
			if (bank0_wr && cpu_addr == `CSTIM_ADDR_TIMER_CLOCK_CONFIG)
				timer_clock_config <= cpu_wdata;
			if (bank0_wr && cpu_addr == `CSTIM_ADDR_CLOCK_OUTPUT_CONFIG)
				clock_output_config <= cpu_wdata & 8'h03;
			if (bank0_wr && cpu_addr == `CSTIM_ADDR_USB_LOCK_TRIM_CONFIG)
				usb_lock_trim_config <= cpu_wdata & 8'h03;
			// Second bank only when flag set [R6]
			if (cpu_wr && extended_io_bank_flag && cpu_addr == `CSTIM_ADDR_OSC_CONTROL_ZERO)
				oscillator_control_zero <= cpu_wdata & 8'h3f;
			if (bank0_wr && cpu_addr == `CSTIM_ADDR_RELOAD_LOW)
				reload_low_stage <= cpu_wdata;
			// Commit whole value on high byte only [R17]
			if (bank0_wr && cpu_addr == `CSTIM_ADDR_RELOAD_HIGH)
				interval_reload_value <= {cpu_wdata[3:0], reload_low_stage};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register reads
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			cpu_rdata <= 8'h00;
		end else if (cpu_rd) begin
			cpu_rdata <= 8'h00;
			if (extended_io_bank_flag) begin
				if (cpu_addr == `CSTIM_ADDR_OSC_CONTROL_ZERO)
					cpu_rdata <= oscillator_control_zero;
			end else begin
				case (cpu_addr)
				`CSTIM_ADDR_CPU_USB_CLOCK_CONFIG: cpu_rdata <= cpu_usb_clock_config;
				`CSTIM_ADDR_TIMER_CLOCK_CONFIG:   cpu_rdata <= timer_clock_config;
				`CSTIM_ADDR_CLOCK_OUTPUT_CONFIG:  cpu_rdata <= clock_output_config;
				`CSTIM_ADDR_USB_LOCK_TRIM_CONFIG: cpu_rdata <= usb_lock_trim_config;
				`CSTIM_ADDR_RELOAD_LOW:           cpu_rdata <= interval_reload_value[7:0];
				`CSTIM_ADDR_RELOAD_HIGH:          cpu_rdata <= {4'h0, interval_reload_value[11:8]};
				default:                          cpu_rdata <= 8'h00;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sleep and supply monitor
	assign supply_monitor_enable = ~sleep_active
		| oscillator_control_zero[`CSTIM_MONITOR_HOLD_BIT] // [R3]
		| sleep_duty_on; // [R4]
	assign sleep_interval_sel = oscillator_control_zero[`CSTIM_SLEEP_TMR_HI:`CSTIM_SLEEP_TMR_LO];
	assign osc24_stop = sleep_active; // [R22]

	////////////////////////////////////////////////////////////////////////////
	// CPU clock
	assign cpu_src_ext   = cpu_usb_clock_config[`CSTIM_CPU_SRC_BIT];
	assign cpu_src_tick  = cpu_src_ext ? ext_tick : osc24_tick; // [R20]
	assign cpu_src_level = cpu_src_ext ? ext_q : osc24_q;

	always @* begin
		case (oscillator_control_zero[`CSTIM_SPEED_HI:`CSTIM_SPEED_LO]) // [R2]
		3'h0:    cpu_divisor = 8'h08;
		3'h1:    cpu_divisor = 8'h04;
		3'h2:    cpu_divisor = 8'h02;
		3'h3:    cpu_divisor = 8'h01;
		3'h4:    cpu_divisor = 8'h10;
		3'h5:    cpu_divisor = 8'h20;
		3'h6:    cpu_divisor = 8'h80;
		default: cpu_divisor = 8'h08;
		endcase
	end

	cstim_div #(.CNT_W(8)) u_cpu_div (
		.ref_clk   (ref_clk),
		.rst_n     (rst_n),
		.src_tick  (cpu_src_tick),
		.src_level (cpu_src_level),
		.divisor   (cpu_divisor),
		.restart   (cpu_src_prev != cpu_src_ext), // [R23]
		.div_clk   (processor_clock),
		.div_tick  ()
	);

	////////////////////////////////////////////////////////////////////////////
	// USB clock and oscillator lock
	assign usb_src_ext = cpu_usb_clock_config[`CSTIM_USB_SRC_BIT];
	assign usb_divisor = (usb_src_ext && cpu_usb_clock_config[`CSTIM_USB_NODIV_BIT]) ?
		2'h1 : 2'h2; // [R21]

	cstim_div #(.CNT_W(2)) u_usb_div (
		.ref_clk   (ref_clk),
		.rst_n     (rst_n),
		.src_tick  (usb_src_ext ? ext_tick : osc24_tick),
		.src_level (usb_src_ext ? ext_q : osc24_q),
		.divisor   (usb_divisor),
		.restart   (usb_src_prev != usb_src_ext),
		.div_clk   (usb_engine_clock),
		.div_tick  ()
	);

	assign osc_lock_enable = ~usb_src_ext // [R7]
		& ~usb_lock_trim_config[`CSTIM_LOCK_DISABLE_BIT]; // [R8]
	assign osc_coarse_enable = osc_lock_enable
		& ~usb_lock_trim_config[`CSTIM_FINE_ONLY_BIT]; // [R9]
	assign osc_trim_strobe = osc_lock_enable & usb_packet_seen; // [R8]

	////////////////////////////////////////////////////////////////////////////
	// Capture timebase
	assign cap_src      = timer_clock_config[`CSTIM_CAP_SRC_HI:`CSTIM_CAP_SRC_LO];
	assign cap_div_code = timer_clock_config[`CSTIM_CAP_DIV_HI:`CSTIM_CAP_DIV_LO];
	// Zero divisor parks the divider when disabled [R11]
	assign cap_divisor  = (cap_src == `CSTIM_SRC_ALT) ? 4'h0 :
		{1'b0, cap_div_code, 1'b0} + 4'h2; // [R10]

	always @* begin
		case (cap_src) // [R11]
		`CSTIM_SRC_OSC24: begin
			cap_src_tick  = osc24_tick;
			cap_src_level = osc24_q;
		end
		`CSTIM_SRC_EXT: begin
			cap_src_tick  = ext_tick;
			cap_src_level = ext_q;
		end
		`CSTIM_SRC_OSC32: begin
			cap_src_tick  = osc32_tick;
			cap_src_level = osc32_q;
		end
		default: begin
			cap_src_tick  = 1'b0;
			cap_src_level = 1'b0;
		end
		endcase
	end

	cstim_div #(.CNT_W(4)) u_cap_div (
		.ref_clk   (ref_clk),
		.rst_n     (rst_n),
		.src_tick  (cap_src_tick),
		.src_level (cap_src_level),
		.divisor   (cap_divisor),
		.restart   (cap_src_prev != cap_src),
		.div_clk   (capture_timebase),
		.div_tick  (cap_tick)
	);

	////////////////////////////////////////////////////////////////////////////
	// Interval timebase
	assign int_src      = timer_clock_config[`CSTIM_INT_SRC_HI:`CSTIM_INT_SRC_LO];
	assign int_div_code = timer_clock_config[`CSTIM_INT_DIV_HI:`CSTIM_INT_DIV_LO];
	assign int_divisor  = {1'b0, int_div_code} + 3'h1; // [R12]

	always @* begin
		case (int_src) // [R13]
		`CSTIM_SRC_OSC24: begin
			int_src_tick  = osc24_tick;
			int_src_level = osc24_q;
		end
		`CSTIM_SRC_EXT: begin
			int_src_tick  = ext_tick;
			int_src_level = ext_q;
		end
		`CSTIM_SRC_OSC32: begin
			int_src_tick  = osc32_tick;
			int_src_level = osc32_q;
		end
		default: begin
			int_src_tick  = cap_tick;
			int_src_level = capture_timebase;
		end
		endcase
	end

	cstim_div #(.CNT_W(3)) u_int_div (
		.ref_clk   (ref_clk),
		.rst_n     (rst_n),
		.src_tick  (int_src_tick),
		.src_level (int_src_level),
		.divisor   (int_divisor),
		.restart   (int_src_prev != int_src),
		.div_clk   (interval_timebase),
		.div_tick  (int_tick)
	);

	////////////////////////////////////////////////////////////////////////////
	// Interval down counter and fixed tick
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			interval_count <= {TIMER_W{1'b0}};
			interval_irq   <= 1'b0;
			fixed_count    <= 13'h0000;
			fixed_tick     <= 1'b0;
		end else begin
			interval_irq <= 1'b0;
			fixed_tick   <= 1'b0;
			if (int_tick) begin
				if (interval_count == {TIMER_W{1'b0}}) begin
					interval_count <= interval_reload_value; // [R15]
					interval_irq   <= 1'b1; // [R16]
				end else begin
					interval_count <= interval_count - {{(TIMER_W-1){1'b0}}, 1'b1}; // [R15]
				end
			end
			if (cap_tick) begin
				if (fixed_count == `CSTIM_FIXED_TICK_LAST) begin
					fixed_count <= 13'h0000;
					fixed_tick  <= 1'b1; // [R18]
				end else begin
					fixed_count <= fixed_count + 13'h0001;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Clock output select
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			clock_output_pin <= 1'b0;
		end else begin
			case (clock_output_config[1:0]) // [R19]
			`CSTIM_SRC_OSC24: clock_output_pin <= osc24_q;
			`CSTIM_SRC_EXT:   clock_output_pin <= ext_q;
			`CSTIM_SRC_OSC32: clock_output_pin <= osc32_q;
			default:          clock_output_pin <= processor_clock;
			endcase
		end
	end

endmodule // cstim_top

//--- cstim_props.sv
/*
 * Concurrent checks on the clock select and interval timer top ports.
 * Assumes one ref_clk domain with synchronous active-low rst_n.
 */
`timescale 1ns/10ps

module cstim_props #(
	parameter TIMER_W = 12
) (
	input logic       ref_clk,
	input logic       rst_n,
	input logic [8:0] cpu_addr,
	input logic       cpu_wr,
	input logic       extended_io_bank_flag,
	input logic       sleep_active,
	input logic       sleep_duty_on,
	input logic       usb_packet_seen,
	input logic [7:0] cpu_rdata,
	input logic       processor_clock,
	input logic       capture_timebase,
	input logic       interval_irq,
	input logic       fixed_tick,
	input logic       supply_monitor_enable,
	input logic       osc24_stop,
	input logic [1:0] sleep_interval_sel,
	input logic       osc_lock_enable,
	input logic       osc_coarse_enable,
	input logic       osc_trim_strobe
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	////////////////////////////////////////////////////////////////////////////
	// Assertions
	AST_MON_AWAKE: assert property ((!sleep_active || sleep_duty_on) |-> supply_monitor_enable)
		else $error("supply monitor off while awake or duty on");
	AST_SLEEP_STOP: assert property (osc24_stop == sleep_active)
		else $error("oscillator stop differs from sleep");
	AST_TRIM_CAUSE: assert property (osc_trim_strobe |-> usb_packet_seen && osc_lock_enable)
		else $error("trim strobe without packet or lock");
	AST_COARSE_LOCK: assert property (osc_coarse_enable |-> osc_lock_enable)
		else $error("coarse tuning without lock");
	AST_SEL_WRITE: assert property ($changed(sleep_interval_sel) && $past(rst_n) |->
		$past(cpu_wr) && $past(cpu_addr) == 9'h1e0 && $past(extended_io_bank_flag))
		else $error("sleep interval changed without banked write");
	AST_IRQ_PULSE: assert property (interval_irq |=> !interval_irq)
		else $error("interval request longer than one cycle");
	AST_TICK_GAP: assert property (fixed_tick |=> !fixed_tick [*8])
		else $error("fixed tick repeats too soon");
	AST_RESET_OUT: assert property ($rose(rst_n) |->
		!processor_clock && !capture_timebase && cpu_rdata == 8'h00)
		else $error("outputs not cleared by reset");

	////////////////////////////////////////////////////////////////////////////
	// Covers
	COV_IRQ: cover property (interval_irq);
	COV_TICK: cover property (fixed_tick);
	COV_TRIM: cover property (osc_trim_strobe);
	COV_DUTY: cover property (sleep_active && !supply_monitor_enable);
endmodule // cstim_props

bind cstim_top cstim_props #(.TIMER_W(TIMER_W)) props_u (.ref_clk, .rst_n, .cpu_addr, .cpu_wr,
	.extended_io_bank_flag, .sleep_active, .sleep_duty_on, .usb_packet_seen, .cpu_rdata,
	.processor_clock, .capture_timebase, .interval_irq, .fixed_tick, .supply_monitor_enable,
	.osc24_stop, .sleep_interval_sel, .osc_lock_enable, .osc_coarse_enable, .osc_trim_strobe);

//--- cstim_tb.sv
/*
 * Register-level testbench for the clock select and interval timer.
 * Assumes oscillator levels are made here, synchronous to ref_clk.
 */
`timescale 1ns/10ps

module tb;
	logic       ref_clk, rst_n, osc24_in, osc32_in, external_clock_pin, bank_wrong;
	logic [8:0] cpu_addr;
	logic [7:0] cpu_wdata;
	logic       cpu_wr, cpu_rd, extended_io_bank_flag, sleep_active, sleep_duty_on;
	logic       usb_packet_seen;
	wire  [7:0] cpu_rdata;
	wire        processor_clock, usb_engine_clock, capture_timebase, interval_timebase;
	wire        clock_output_pin, interval_irq, fixed_tick, supply_monitor_enable, osc24_stop;
	wire  [1:0] sleep_interval_sel;
	wire        osc_lock_enable, osc_coarse_enable, osc_trim_strobe;
	int         failures, comparisons, cycles, i, p;
	int         divs[8] = '{8, 4, 2, 1, 16, 32, 128, 8};
	int         outp[4] = '{2, 6, 16, 8};
	logic [7:0] cap_cfg[6] = '{8'h00, 8'h40, 8'h80, 8'hc0, 8'h10, 8'h20};
	int         cap_p[6] = '{4, 8, 12, 16, 12, 32};
	logic [7:0] itv_cfg[8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h01, 8'h02, 8'h03, 8'h0f};
	int         itv_p[8] = '{2, 4, 6, 8, 6, 16, 4, 16};
	wire  [6:0] probe = {usb_engine_clock, fixed_tick, interval_irq, interval_timebase,
		capture_timebase, clock_output_pin, processor_clock};

	cstim_top dut_u (.ref_clk, .rst_n, .osc24_in, .osc32_in, .external_clock_pin, .cpu_addr,
		.cpu_wdata, .cpu_wr, .cpu_rd, .extended_io_bank_flag, .sleep_active, .sleep_duty_on,
		.usb_packet_seen, .cpu_rdata, .processor_clock, .usb_engine_clock, .capture_timebase,
		.interval_timebase, .clock_output_pin, .interval_irq, .fixed_tick,
		.supply_monitor_enable, .osc24_stop, .sleep_interval_sel, .osc_lock_enable,
		.osc_coarse_enable, .osc_trim_strobe);

	////////////////////////////////////////////////////////////////////////////
	// Clock, oscillator levels, run limit
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		osc24_in <= ~osc24_in;
		if (cycles % 3 == 2)
			external_clock_pin <= ~external_clock_pin;
		if (cycles % 8 == 7)
			osc32_in <= ~osc32_in;
		if (cycles == 90000) begin
			failures++;
			finish_test;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Tasks
	task finish_test;
		if (failures == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task check(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	task wr(input logic [8:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		cpu_addr <= a;
		cpu_wdata <= d;
		extended_io_bank_flag <= a[8] ^ bank_wrong;
		cpu_wr <= 1'b1;
		@(posedge ref_clk);
		cpu_wr <= 1'b0;
	endtask

	task rd_chk(input logic [8:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		cpu_addr <= a;
		extended_io_bank_flag <= a[8];
		cpu_rd <= 1'b1;
		@(posedge ref_clk);
		cpu_rd <= 1'b0;
		@(negedge ref_clk);
		check({8'h00, cpu_rdata}, {8'h00, e});
	endtask

	// Cycles between the second and third rising edges of one probe
	task period(input int k, input int lim, output int n);
		logic prev;
		int   m;
		n = 0;
		for (m = 0; m < 3 && n < lim; m++) begin
			n = 0;
			do begin
				prev = probe[k];
				@(negedge ref_clk);
				n++;
			end while (!(prev === 1'b0 && probe[k] === 1'b1) && n < lim);
		end
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{rst_n, osc24_in, osc32_in, external_clock_pin, bank_wrong, cpu_wr, cpu_rd} = '0;
		{extended_io_bank_flag, sleep_active, sleep_duty_on, usb_packet_seen} = '0;
		{cpu_addr, cpu_wdata, failures, comparisons, cycles} = '0;
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'b1;
		period(0, 600, p);
		check(p[15:0], 16'd16);
		period(3, 600, p);
		check(p[15:0], 16'd48);
		period(6, 600, p);
		check(p[15:0], 16'd4);
		rd_chk(9'h031, 8'h8f);
		rd_chk(9'h032, 8'h00);
		rd_chk(9'h1e0, 8'h00);
		rd_chk(9'h033, 8'h00);
		wr(9'h030, 8'hff);
		rd_chk(9'h030, 8'h61);
		check({14'h0, osc_lock_enable, osc_coarse_enable}, 16'h0);
		period(6, 600, p);
		check(p[15:0], 16'd6);
		wr(9'h030, 8'h01);
		bank_wrong = 1'b1;
		wr(9'h1e0, 8'h18);
		bank_wrong = 1'b0;
		rd_chk(9'h1e0, 8'h00);
		wr(9'h1e0, 8'hff);
		rd_chk(9'h1e0, 8'h3f);
		check({14'h0, sleep_interval_sel}, 16'h3);
		@(posedge ref_clk);
		sleep_active <= 1'b1;
		@(negedge ref_clk);
		check({14'h0, supply_monitor_enable, osc24_stop}, 16'h3);
		rd_chk(9'h030, 8'h00);
		wr(9'h1e0, 8'h07);
		@(negedge ref_clk);
		check({15'h0, supply_monitor_enable}, 16'h0);
		@(posedge ref_clk);
		sleep_duty_on <= 1'b1;
		@(negedge ref_clk);
		check({15'h0, supply_monitor_enable}, 16'h1);
		@(posedge ref_clk);
		sleep_active <= 1'b0;
		sleep_duty_on <= 1'b0;
		for (i = 0; i < 8; i++) begin
			wr(9'h1e0, 8'(i));
			period(0, 600, p);
			check(p[15:0], 16'(2 * divs[i]));
		end
		wr(9'h1e0, 8'h01);
		for (i = 0; i < 4; i++) begin
			wr(9'h032, 8'(i));
			period(1, 600, p);
			check(p[15:0], 16'(outp[i]));
		end
		for (i = 0; i < 6; i++) begin
			wr(9'h031, cap_cfg[i]);
			period(2, 600, p);
			check(p[15:0], 16'(cap_p[i]));
		end
		wr(9'h031, 8'h30);
		period(2, 100, p);
		check(p[15:0], 16'd100);
		for (i = 0; i < 8; i++) begin
			wr(9'h031, itv_cfg[i]);
			period(3, 600, p);
			check(p[15:0], 16'(itv_p[i]));
		end
		wr(9'h031, 8'h00);
		wr(9'h01b, 8'h05);
		rd_chk(9'h01b, 8'h00);
		wr(9'h01c, 8'h01);
		rd_chk(9'h01c, 8'h01);
		wr(9'h01b, 8'h00);
		period(4, 2000, p);
		check(p[15:0], 16'd524);
		rd_chk(9'h01b, 8'h05);
		@(posedge ref_clk);
		usb_packet_seen <= 1'b1;
		@(negedge ref_clk);
		check({15'h0, osc_trim_strobe}, 16'h1);
		@(posedge ref_clk);
		usb_packet_seen <= 1'b0;
		wr(9'h039, 8'h01);
		usb_packet_seen <= 1'b1;
		@(negedge ref_clk);
		check({14'h0, osc_lock_enable, osc_trim_strobe}, 16'h0);
		@(posedge ref_clk);
		usb_packet_seen <= 1'b0;
		wr(9'h039, 8'h02);
		@(negedge ref_clk);
		check({14'h0, osc_lock_enable, osc_coarse_enable}, 16'h2);
		wr(9'h039, 8'hff);
		rd_chk(9'h039, 8'h03);
		period(5, 20000, p);
		check(p[15:0], 16'd16384);
		finish_test;
	end
endmodule // tb
